// ==== amtt_top.sv ====
// Purpose: sticky out-of-limit status, alert masking and pin routing, throttle assertion timer
// Assumes: limit comparators and the serial interface engine share clk_i
// Notes: register access arrives as single-cycle read/write strobes from the serial engine
//
// Contract
// - an out-of-limit condition sets its channel status bit
// - status bit clears only after condition ended and status register read
// - alert low while any unmasked reading bad, then until status read
// - mask bits gate only the alert; status still sets
// - first mask: summary, remote two, local, remote one, supply, 2.5 V
// - second mask: diode two, diode one, fans three to one, critical limit
// - second mask bit 5 blocks fourth fan or throttle timer alert
// - alert off after reset; third config bit 0 enables primary pin
// - fourth config bit 0 routes alert to secondary pin
// - timer counts while throttle asserted, holds while negated, accumulates
// - timer clears on read, saturates at full scale
// - bit 0 set on first assertion, then 22.76 ms per count
// - read during assertion restarts timer at one, limit zero flags again
// - timer above limit sets status two bit 5 and alerts unless masked
// - limit zero trips on first assertion, one after 45.52 ms
// - third config bit 1 enables throttle monitoring
// - third config bit 2 forces full fan drive during throttle assertion
// - status one bit 7 set whenever any status two bit set
// - status two bit 5 is timer over limit while monitoring on, else fourth fan underspeed
`timescale 1ns/1ps
`default_nettype none
module amtt_top
    import amtt_pkg::*;
#(
    parameter int unsigned TICK_CYC = THR_TICK_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register access from serial engine
    input wire amtt_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    // raw limit comparator results, bit positions as status registers
    input wire logic [7:0] first_cond_i,
    input wire logic [7:0] second_cond_i,
    // throttle pin, active low, asynchronous
    input wire logic throttle_n_i,
    // alert pins, open drain
    output amtt_od_t primary_alert_o,
    output amtt_od_t secondary_alert_o,
    // fan drive override
    output logic fan_boost_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [7:0] first_mask_q;
    logic [7:0] second_mask_q;
    logic [7:0] third_cfg_q;
    logic [7:0] limit_q;
    logic [7:0] fourth_cfg_q;
    logic [7:0] st1_q;
    logic [7:0] st2_q;
    logic thr_s1_q;
    logic thr_s2_q;
    logic seen_q;
    logic [7:0] ticks_q;
    logic [23:0] sub_q;
    logic alert_q;
    logic prim_oe_q;
    logic sec_oe_q;
    logic drive_low_q;
    logic boost_q;
    logic [7:0] rdata_q;

    logic wr_w;
    logic rd_w;
    logic rd_st1_w;
    logic rd_st2_w;
    logic rd_timer_w;
    logic thr_w;
    logic cnt_w;
    logic tick_w;
    logic [7:0] timer_w;
    logic timer_trip_w;
    logic [7:0] cond1_w;
    logic [7:0] cond2_w;
    logic [7:0] st1_view_w;
    logic alert_w;

    assign wr_w = reg_req_i.wr;
    assign rd_w = reg_req_i.rd;
    assign rd_st1_w = rd_w && (reg_req_i.addr == STATUS_ONE_OFS);
    assign rd_st2_w = rd_w && (reg_req_i.addr == STATUS_TWO_OFS);
    assign rd_timer_w = rd_w && (reg_req_i.addr == TIMER_OFS);

    // writable registers; defaults zero so alerts stay off until enabled
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_mask_q <= MASK_RST;
            second_mask_q <= MASK_RST;
            third_cfg_q <= CFG_RST;
            limit_q <= LIMIT_RST;
            fourth_cfg_q <= CFG_RST;
        end else if (wr_w) begin
            case (reg_req_i.addr)
                FIRST_MASK_OFS: first_mask_q <= reg_req_i.wdata;
                SECOND_MASK_OFS: second_mask_q <= reg_req_i.wdata;
                THIRD_CFG_OFS: third_cfg_q <= reg_req_i.wdata;
                LIMIT_OFS: limit_q <= reg_req_i.wdata;
                FOURTH_CFG_OFS: fourth_cfg_q <= reg_req_i.wdata;
                default: ;
            endcase
        end
    end

    // throttle pin through two flops before use
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            thr_s1_q <= 1'b1;
            thr_s2_q <= 1'b1;
        end else begin
            thr_s1_q <= throttle_n_i;
            thr_s2_q <= thr_s1_q;
        end
    end

    assign thr_w = !thr_s2_q;
    assign cnt_w = thr_w && third_cfg_q[THR_EN_BIT];
    assign tick_w = (sub_q == 24'(TICK_CYC - 1));

    // cumulative timer: sub_q keeps the fraction of a count across pauses
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            seen_q <= 1'b0;
            ticks_q <= 8'h00;
            sub_q <= 24'h000000;
        end else if (rd_timer_w) begin
            // restart; an ongoing assertion shows as one at once
            seen_q <= cnt_w;
            ticks_q <= 8'h00;
            sub_q <= 24'h000000;
        end else if (cnt_w) begin
            seen_q <= 1'b1;
            if (tick_w) begin
                sub_q <= 24'h000000;
                if (ticks_q != TIMER_FULL) begin
                    ticks_q <= ticks_q + 8'h01;
                end
            end else begin
                sub_q <= sub_q + 24'h000001;
            end
        end
    end

    // below two counts only the first-assertion flag shows
    assign timer_w = (ticks_q >= TIMER_FINE) ? ticks_q : {7'h00, seen_q};
    assign timer_trip_w = third_cfg_q[THR_EN_BIT] && (timer_w > limit_q);

    // fourth fan bit is shared with the timer when monitoring is on
    always_comb begin
        cond1_w = first_cond_i & ST1_USED;
        cond2_w = second_cond_i & ST2_USED;
        if (third_cfg_q[THR_EN_BIT]) begin
            cond2_w[F4P_BIT] = timer_trip_w;
        end
    end

    // sticky status: a condition present on the read cycle wins over the clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st1_q <= 8'h00;
            st2_q <= 8'h00;
        end else begin
            st1_q <= (rd_st1_w ? 8'h00 : st1_q) | cond1_w;
            st2_q <= (rd_st2_w ? 8'h00 : st2_q) | cond2_w;
        end
    end

    always_comb begin
        st1_view_w = st1_q;
        st1_view_w[SUMMARY_BIT] = |st2_q;
    end

    // summary mask bit blocks all of status two as well as each own mask
    assign alert_w = (|(st1_q & ST1_USED & ~first_mask_q))
        || ((|(st2_q & ST2_USED & ~second_mask_q)) && !first_mask_q[SUMMARY_BIT]);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            alert_q <= 1'b0;
            prim_oe_q <= 1'b0;
            sec_oe_q <= 1'b0;
            drive_low_q <= 1'b0;
        end else begin
            alert_q <= alert_w;
            prim_oe_q <= alert_w && third_cfg_q[ALERT_EN_BIT];
            sec_oe_q <= alert_w && fourth_cfg_q[SEC_EN_BIT];
            drive_low_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            boost_q <= 1'b0;
        end else begin
            boost_q <= thr_w && third_cfg_q[BOOST_BIT];
        end
    end

    // read data captured before any clear-on-read takes effect
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (rd_w) begin
            case (reg_req_i.addr)
                STATUS_ONE_OFS: rdata_q <= st1_view_w;
                STATUS_TWO_OFS: rdata_q <= st2_q;
                FIRST_MASK_OFS: rdata_q <= first_mask_q;
                SECOND_MASK_OFS: rdata_q <= second_mask_q;
                THIRD_CFG_OFS: rdata_q <= third_cfg_q;
                TIMER_OFS: rdata_q <= timer_w;
                LIMIT_OFS: rdata_q <= limit_q;
                FOURTH_CFG_OFS: rdata_q <= fourth_cfg_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_o = rdata_q;
    assign primary_alert_o = '{out: drive_low_q, oe: prim_oe_q};
    assign secondary_alert_o = '{out: drive_low_q, oe: sec_oe_q};
    assign fan_boost_o = boost_q;

    status_set_a: assert property ((cond1_w != 8'h00) |=> ((st1_q & $past(cond1_w)) == $past(cond1_w)))
        else $error("status one bit missed its condition");
    sticky_hold_a: assert property (!rd_st2_w |=> ((st2_q & $past(st2_q)) == $past(st2_q)))
        else $error("status two bit dropped without a read");
    read_clear_a: assert property ((rd_st1_w && cond1_w == 8'h00) |=> (st1_q & ST1_USED) == 8'h00)
        else $error("status one not cleared by read");
    alert_cause_a: assert property ((|(st1_q & ~first_mask_q & ST1_USED)) |=> alert_q)
        else $error("alert not raised for unmasked status");
    mask_status_a: assert property (((cond2_w & second_mask_q) != 8'h00)
        |=> ((st2_q & $past(cond2_w & second_mask_q)) == $past(cond2_w & second_mask_q)))
        else $error("masked source lost its status");
    primary_off_a: assert property (!third_cfg_q[ALERT_EN_BIT] |=> !primary_alert_o.oe)
        else $error("primary alert pin driven while disabled");
    secondary_pin_a: assert property ((fourth_cfg_q[SEC_EN_BIT] && alert_w) |=> secondary_alert_o.oe)
        else $error("secondary alert pin not driven");
    timer_pause_a: assert property ((!cnt_w && !rd_timer_w) |=> $stable(ticks_q) && $stable(sub_q))
        else $error("timer moved while throttle negated");
    timer_sat_a: assert property ((ticks_q == TIMER_FULL && !rd_timer_w) |=> ticks_q == TIMER_FULL)
        else $error("timer left full scale without read");
    read_restart_a: assert property ((rd_timer_w && cnt_w) |=> timer_w == 8'h01 ##1 (timer_w != 8'h00))
        else $error("timer not restarted at one");
    limit_flag_a: assert property (timer_trip_w |=> st2_q[F4P_BIT] && st1_view_w[SUMMARY_BIT])
        else $error("timer over limit not flagged");
    summary_read_a: assert property (rd_st1_w |=> reg_rdata_o[SUMMARY_BIT] == $past(|st2_q))
        else $error("summary bit disagrees with status two");
    boost_a: assert property ((third_cfg_q[BOOST_BIT] && thr_w) |=> fan_boost_o)
        else $error("fan boost missing during throttle");

    // further guards on pin routing, masking, timer stepping and the synchroniser;
    // each except drain_low_a looks one edge ahead, since every output here is a registered copy
    // of the combinational decision made in the cycle before

    primary_pin_a: assert property ((third_cfg_q[ALERT_EN_BIT] && alert_w) |=> primary_alert_o.oe)
        else $error("primary alert pin not driven");

    secondary_off_a: assert property (!fourth_cfg_q[SEC_EN_BIT] |=> !secondary_alert_o.oe)
        else $error("secondary alert pin driven while disabled");

    full_mask_a: assert property ((first_mask_q == 8'hFF && second_mask_q == 8'hFF) |=> !alert_q)
        else $error("alert raised with every source masked");

    alert_quiet_a: assert property (((st1_q & ST1_USED & ~first_mask_q) == 8'h00
        && (st2_q & ST2_USED & ~second_mask_q) == 8'h00) |=> !alert_q)
        else $error("alert raised without unmasked status");

    timer_step_a: assert property ((cnt_w && !rd_timer_w && tick_w && ticks_q != TIMER_FULL)
        |=> ticks_q == $past(ticks_q) + 8'h01)
        else $error("timer missed a tick");

    first_flag_a: assert property ((cnt_w && !rd_timer_w) |=> seen_q)
        else $error("first assertion flag not set");

    timer_clear_a: assert property ((rd_timer_w && !cnt_w) |=> timer_w == 8'h00)
        else $error("timer not cleared by read");

    monitor_off_a: assert property ((!third_cfg_q[THR_EN_BIT] && !rd_timer_w) |=> $stable(ticks_q))
        else $error("timer moved with monitoring off");

    boost_off_a: assert property (!third_cfg_q[BOOST_BIT] |=> !fan_boost_o)
        else $error("fan boost without enable");

    sync_delay_a: assert property ($fell(thr_s1_q) |=> !thr_s2_q)
        else $error("throttle synchroniser skipped a stage");

    rdata_hold_a: assert property (!rd_w |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    // the open-drain value never drives high; only the enables move
    drain_low_a: assert property (!primary_alert_o.out && !secondary_alert_o.out)
        else $error("alert pin driven high");
endmodule
`default_nettype wire

// ==== amtt_pkg.sv ====
// Purpose: constants and carrier types of the alert mask and throttle timer block
// Assumes: 40 MHz core clock
// Notes: register offsets are the register numbers seen by the serial interface engine
package amtt_pkg;
    // register offsets
    localparam logic [7:0] STATUS_ONE_OFS = 8'h41;
    localparam logic [7:0] STATUS_TWO_OFS = 8'h42;
    localparam logic [7:0] FIRST_MASK_OFS = 8'h74;
    localparam logic [7:0] SECOND_MASK_OFS = 8'h75;
    localparam logic [7:0] THIRD_CFG_OFS = 8'h78;
    localparam logic [7:0] TIMER_OFS = 8'h79;
    localparam logic [7:0] LIMIT_OFS = 8'h7A;
    localparam logic [7:0] FOURTH_CFG_OFS = 8'h7D;
    // reset values
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] LIMIT_RST = 8'h00;
    // field positions
    localparam int ALERT_EN_BIT = 0;
    localparam int THR_EN_BIT = 1;
    localparam int BOOST_BIT = 2;
    localparam int SEC_EN_BIT = 0;
    localparam int SUMMARY_BIT = 7;
    localparam int F4P_BIT = 5;
    // implemented status bits, timer full scale and fine threshold
    localparam logic [7:0] ST1_USED = 8'h75;
    localparam logic [7:0] ST2_USED = 8'hFE;
    localparam logic [7:0] TIMER_FULL = 8'hFF;
    localparam logic [7:0] TIMER_FINE = 8'h02;
    // timing: one timer count, full scale is 255 counts (about 5.804 s)
    localparam int CLK_NS = 25;
    localparam int THR_TICK_NS = 22760000;
    localparam int THR_TICK_CYC = THR_TICK_NS / CLK_NS;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } amtt_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } amtt_od_t;
endpackage

// ==== amtt_host.sv ====
// Purpose: host model issuing register strobes to the alert and throttle timer block
// Assumes: one request at a time, strobes launched just after a rising edge
// Notes: released address and data lines carry inverted values, never the last ones
`timescale 1ns/1ps
`default_nettype none
module amtt_host
    import amtt_pkg::*;
(
    // clock
    input wire logic clk_i,
    // register strobes
    output var amtt_req_t req_o,
    input wire logic [7:0] rdata_i
);
    initial req_o = '0;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{a, 1'b1, 1'b0, d};
        @(posedge clk_i);
        req_o <= '{~a, 1'b0, 1'b0, ~d};
    endtask

    // read data is taken after the edge that sampled the strobe has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk_i);
        req_o <= '{~a, 1'b0, 1'b0, 8'hFF};
        #1 d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench of the alert mask and throttle timer block
// Assumes: short timer tick of 8 cycles
// Notes: expectations come from a small integer model of registers and timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import amtt_pkg::*;
    localparam int TK = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic thr_n = 1'b1;
    logic [15:0] cond = 16'h0;
    logic [15:0] b;
    logic [7:0] rdata;
    logic [7:0] e;
    logic boost;
    amtt_req_t req;
    amtt_od_t pa;
    amtt_od_t sa;
    int err_count = 0;
    int num_checks = 0;
    int acc = 0;
    int regs [5];
    logic [7:0] ofs [5] = '{FIRST_MASK_OFS, SECOND_MASK_OFS, THIRD_CFG_OFS, LIMIT_OFS, FOURTH_CFG_OFS};

    always #12.5 clk_i = ~clk_i;

    amtt_top #(.TICK_CYC(TK)) DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .first_cond_i(cond[7:0]), .second_cond_i(cond[15:8]), .throttle_n_i(thr_n),
        .primary_alert_o(pa), .secondary_alert_o(sa), .fan_boost_o(boost));
    amtt_host host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, x);
    endtask

    task automatic oe(input logic [1:0] x);
        #1 chk({6'h0, sa.oe, pa.oe}, {6'h0, x});
    endtask

    // timer model: first-assertion flag until two whole ticks, then ticks, saturating
    function automatic logic [7:0] texp(int c);
        int t = c / TK;
        return (t > 255) ? 8'hFF : (t >= 2) ? 8'(t) : (c > 0) ? 8'h01 : 8'h00;
    endfunction

    task automatic rdt;
        rdc(TIMER_OFS, texp(acc));
        acc = 0;
    endtask

    task automatic thr(input int n, input bit en, input logic bx);
        @(posedge clk_i) thr_n <= 1'b0;
        repeat (n) @(posedge clk_i);
        #1 chk({7'h0, boost}, {7'h0, bx});
        @(posedge clk_i) thr_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        if (en)
            acc += n + 1;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h3374));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ofs[i]) rdc(ofs[i], 8'h00);
        rdc(TIMER_OFS, 8'h00);
        rdc(8'h10, 8'h00);
        oe(2'h0);
        foreach (ofs[i]) begin
            regs[i] = $urandom_range(255);
            host.wr(ofs[i], 8'(regs[i]));
        end
        host.wr(TIMER_OFS, 8'h55);
        foreach (ofs[i]) rdc(ofs[i], 8'(regs[i]));
        rdc(TIMER_OFS, 8'h00);
        host.wr(THIRD_CFG_OFS, 8'h01);
        host.wr(FOURTH_CFG_OFS, 8'h01);
        host.wr(LIMIT_OFS, 8'h00);
        for (int i = 0; i < 16; i++) begin
            if ((i < 8) ? ST1_USED[i % 8] : ST2_USED[i % 8]) begin
                for (int m = 0; m < ((i < 8) ? 2 : 3); m++) begin
                    b = 16'h1 << i;
                    e = (i < 8) ? b[7:0] : 8'h80;
                    host.wr(FIRST_MASK_OFS, (m == 2) ? 8'h80 : (m == 1) ? b[7:0] : 8'h00);
                    host.wr(SECOND_MASK_OFS, (m == 1) ? b[15:8] : 8'h00);
                    @(posedge clk_i) cond <= b;
                    repeat (3) @(posedge clk_i);
                    oe((m > 0) ? 2'h0 : 2'h3);
                    rdc(STATUS_ONE_OFS, e);
                    @(posedge clk_i) cond <= 16'h0;
                    rdc(STATUS_ONE_OFS, e);
                    rdc(STATUS_TWO_OFS, b[15:8]);
                    rdc(STATUS_ONE_OFS, 8'h00);
                    @(posedge clk_i);
                    oe(2'h0);
                end
            end
        end
        host.wr(FIRST_MASK_OFS, 8'h00);
        host.wr(SECOND_MASK_OFS, 8'h00);
        host.wr(THIRD_CFG_OFS, 8'h05);
        thr(9, 1'b0, 1'b1);
        rdt();
        host.wr(THIRD_CFG_OFS, 8'h03);
        thr(3, 1'b1, 1'b0);
        oe(2'h3);
        rdc(STATUS_TWO_OFS, 8'h20);
        rdt();
        host.wr(LIMIT_OFS, 8'h01);
        rdc(STATUS_TWO_OFS, 8'h20);
        rdc(STATUS_TWO_OFS, 8'h00);
        thr(9, 1'b1, 1'b0);
        rdc(STATUS_TWO_OFS, 8'h00);
        thr(9, 1'b1, 1'b0);
        oe(2'h3);
        rdc(STATUS_TWO_OFS, 8'h20);
        // host services the source: mask it, act, then unmask once it clears
        host.wr(SECOND_MASK_OFS, 8'h20);
        repeat (2) @(posedge clk_i);
        oe(2'h0);
        rdt();
        rdc(STATUS_TWO_OFS, 8'h20);
        host.wr(SECOND_MASK_OFS, 8'h00);
        host.wr(LIMIT_OFS, 8'h00);
        @(posedge clk_i) thr_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        rdc(TIMER_OFS, 8'h01);
        repeat (2) @(posedge clk_i);
        thr_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        rdc(TIMER_OFS, 8'h01);
        rdc(STATUS_TWO_OFS, 8'h20);
        thr(2100, 1'b1, 1'b0);
        rdt();
        rdc(TIMER_OFS, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
